// ===== hw/pcs_pkg.sv
// Overview of operation
// - Three-bit writable power class, reset 000, loaded from strap pins after reset release, drives self-ID power.
// - Codes 000-011: no power, or self-powered giving 15, 30, 45 W.
// - Codes 100-111: bus-powered using 1 W, needing 0, 2, 5, 9 W more.
// - Read-only delay spread field, reset zero, meaning (value+1)*20 ns.
// - Resume enable bit, reset zero, lets resume start set the port event flag.
// - Writing one to short reset request arbitrates then short-resets; bit self-clears.
// - Loop detect flag resets zero, cleared by writing one.
// - Cable power loss flag sets on present bit falling; write one clears.
// - Arbitration timeout flag, reset zero, cleared by writing one.
// - Port event sets when enabled port's connected, bias, disabled or error changes.
// - Port event also sets on resume start when enabled; reset zero; write one clears.
// - Arbitration acceleration enable bit, reset zero, turns on accelerated arbitration.
// - Three-bit page choice, reset 000, selects page shown at window 1000b-1001b.
// - Four-bit port choice, reset 0000, selects port shown in per-port pages.
// - Page zero shows line states, child, connected, bias, disabled; then speed, enable, error.
// - Per-port change enable, reset zero, permits port event on status changes.
// - Per-port error sets on suspend or resume error; write one clears.
package pcs_pkg;
    localparam int PCS_NUM_PORTS = 3;

    // Register indices; byte address is four times the index
    localparam logic [3:0] PCS_IDX_PWR = 4'h4;
    localparam logic [3:0] PCS_IDX_EVT = 4'h5;
    localparam logic [3:0] PCS_IDX_SEL = 4'h7;
    localparam logic [3:0] PCS_IDX_PSTAT = 4'h8;
    localparam logic [3:0] PCS_IDX_PCTRL = 4'h9;

    // Power class and delay spread register
    localparam int PCS_PWR_LSB = 0;
    localparam int PCS_JIT_LSB = 3;
    localparam logic [2:0] PCS_JITTER_VALUE = 3'h0;

    // Event and control register
    localparam int PCS_EV_RESUME_EN = 7;
    localparam int PCS_EV_SHORT_RST = 6;
    localparam int PCS_EV_LOOP = 5;
    localparam int PCS_EV_PWR_FAIL = 4;
    localparam int PCS_EV_TIMEOUT = 3;
    localparam int PCS_EV_PORT_EVT = 2;
    localparam int PCS_EV_ACCEL = 1;
    localparam int PCS_EV_MULTI = 0;

    // Page and port select register
    localparam int PCS_SEL_PAGE_LSB = 5;
    localparam int PCS_SEL_PORT_LSB = 0;
    localparam logic [2:0] PCS_PAGE_RESET = 3'h0;
    localparam logic [3:0] PCS_PORT_RESET = 4'h0;
    localparam logic [2:0] PCS_PAGE_STATUS = 3'h0;

    // Port status page, first byte
    localparam int PCS_PS_ASTAT_LSB = 6;
    localparam int PCS_PS_BSTAT_LSB = 4;
    localparam int PCS_PS_CHILD = 3;
    localparam int PCS_PS_CONN = 2;
    localparam int PCS_PS_BIAS = 1;
    localparam int PCS_PS_DIS = 0;

    // Port status page, second byte
    localparam int PCS_PC_SPEED_LSB = 5;
    localparam int PCS_PC_INT_EN = 4;
    localparam int PCS_PC_FAULT = 3;

    localparam logic [1:0] PCS_HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic [1:0] PCS_HRESP_OKAY = 2'h0;
    localparam logic [1:0] PCS_STRAP_SETTLE = 2'h3;
endpackage

// ===== hw/pcs_port_status.sv
`timescale 1ns/1ns
module pcs_port_status
    import pcs_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic connected_in,
    input wire logic bias_in,
    input wire logic fault_event_in,
    input wire logic wr_status_in,
    input wire logic wr_ctrl_in,
    input wire logic [7:0] wdata_in,
    output logic disabled_out,
    output logic int_enable_out,
    output logic fault_out,
    output logic change_event_out
);
    logic prev_connected;
    logic prev_bias;
    logic prev_disabled;
    logic prev_fault;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            disabled_out <= 1'b0;
        end else if (wr_status_in) begin
            disabled_out <= wdata_in[PCS_PS_DIS];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            int_enable_out <= 1'b0;
        end else if (wr_ctrl_in) begin
            int_enable_out <= wdata_in[PCS_PC_INT_EN];
        end
    end

    // Error flag: new error wins over a clearing write
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            fault_out <= 1'b0;
        end else begin
            fault_out <= (fault_out & ~(wr_ctrl_in & wdata_in[PCS_PC_FAULT]))
                | fault_event_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            prev_connected <= 1'b0;
            prev_bias <= 1'b0;
            prev_disabled <= 1'b0;
            prev_fault <= 1'b0;
        end else begin
            prev_connected <= connected_in;
            prev_bias <= bias_in;
            prev_disabled <= disabled_out;
            prev_fault <= fault_out;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            change_event_out <= 1'b0;
        end else begin
            change_event_out <= int_enable_out & ((prev_connected ^ connected_in)
                | (prev_bias ^ bias_in) | (prev_disabled ^ disabled_out)
                | (prev_fault ^ fault_out));
        end
    end
endmodule

// ===== hw/pcs_regs.sv
`timescale 1ns/1ns
module pcs_regs
    import pcs_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,

    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic [1:0] hresp_out,

    input wire logic [2:0] power_class_strap_pins_in,
    input wire logic cable_power_present_in,

    input wire logic [PCS_NUM_PORTS-1:0][1:0] port_astat_in,
    input wire logic [PCS_NUM_PORTS-1:0][1:0] port_bstat_in,
    input wire logic [PCS_NUM_PORTS-1:0] port_child_in,
    input wire logic [PCS_NUM_PORTS-1:0] port_connected_in,
    input wire logic [PCS_NUM_PORTS-1:0] port_bias_in,
    input wire logic [PCS_NUM_PORTS-1:0][2:0] port_speed_in,
    input wire logic [PCS_NUM_PORTS-1:0] port_fault_event_in,
    input wire logic [PCS_NUM_PORTS-1:0] port_resume_start_in,

    input wire logic loop_detect_in,
    input wire logic arb_timeout_in,
    input wire logic short_reset_done_in,

    output logic [2:0] power_class_out,
    output logic short_reset_request_out,
    output logic arb_accel_enable_out,
    output logic multi_speed_enable_out,
    output logic [PCS_NUM_PORTS-1:0] port_disabled_out
);
    // ************************************************************
    // Bus slave state
    // ************************************************************
    logic dp_write, dp_read;
    logic [3:0] dp_index;
    logic addr_mapped;
    logic take_transfer;
    logic [7:0] wbyte;
    logic [7:0] next_rdata;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [2:0] pwr_class;
    logic resume_enable;
    logic loop_flag, pwr_fail_flag, timeout_flag, port_event_flag;
    logic accel_enable;
    logic multi_enable;
    logic [2:0] page_select;
    logic [3:0] port_select;

    logic wr_pwr, wr_evt, wr_sel, wr_pstat, wr_pctrl;
    logic port_page_ok;

    logic [2:0] strap_s1, strap_s2, strap_s3;
    logic [1:0] strap_count;
    logic strap_loaded;

    logic ps_s1, ps_s2, ps_s3;
    logic ps_state;
    logic ps_fall;

    logic [PCS_NUM_PORTS-1:0] pp_disabled;
    logic [PCS_NUM_PORTS-1:0] pp_int_enable;
    logic [PCS_NUM_PORTS-1:0] pp_fault;
    logic [PCS_NUM_PORTS-1:0] pp_change;
    logic [PCS_NUM_PORTS-1:0] pp_wr_status, pp_wr_ctrl;

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    assign take_transfer = hsel_in & hready_in & htrans_in[1];
    assign addr_mapped = (haddr_in[31:6] == 26'h0) & (haddr_in[1:0] == 2'h0);
    assign wbyte = hwdata_in[7:0];

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_index <= 4'h0;
        end else begin
            dp_write <= take_transfer & hwrite_in & addr_mapped;
            dp_read <= take_transfer & ~hwrite_in;
            if (take_transfer) begin
                dp_index <= addr_mapped ? haddr_in[5:2] : 4'hF;
            end
        end
    end

    // Reads take one wait state so a read right after a write sees it
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            hreadyout_out <= 1'b1;
        end else begin
            hreadyout_out <= ~(take_transfer & ~hwrite_in);
        end
        hresp_out <= PCS_HRESP_OKAY;
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            hrdata_out <= 32'h0;
        end else if (dp_read) begin
            hrdata_out <= {24'h0, next_rdata};
        end
    end

    assign wr_pwr = dp_write & (dp_index == PCS_IDX_PWR);
    assign wr_evt = dp_write & (dp_index == PCS_IDX_EVT);
    assign wr_sel = dp_write & (dp_index == PCS_IDX_SEL);
    assign port_page_ok = (page_select == PCS_PAGE_STATUS)
        & (port_select < 4'(PCS_NUM_PORTS));
    assign wr_pstat = dp_write & (dp_index == PCS_IDX_PSTAT) & port_page_ok;
    assign wr_pctrl = dp_write & (dp_index == PCS_IDX_PCTRL) & port_page_ok;

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    always_comb begin
        next_rdata = 8'h0;
        case (dp_index)
            PCS_IDX_PWR: begin
                next_rdata[PCS_PWR_LSB +: 3] = pwr_class;
                next_rdata[PCS_JIT_LSB +: 3] = PCS_JITTER_VALUE;
            end
            PCS_IDX_EVT: begin
                next_rdata[PCS_EV_RESUME_EN] = resume_enable;
                next_rdata[PCS_EV_SHORT_RST] = short_reset_request_out;
                next_rdata[PCS_EV_LOOP] = loop_flag;
                next_rdata[PCS_EV_PWR_FAIL] = pwr_fail_flag;
                next_rdata[PCS_EV_TIMEOUT] = timeout_flag;
                next_rdata[PCS_EV_PORT_EVT] = port_event_flag;
                next_rdata[PCS_EV_ACCEL] = accel_enable;
                next_rdata[PCS_EV_MULTI] = multi_enable;
            end
            PCS_IDX_SEL: begin
                next_rdata[PCS_SEL_PAGE_LSB +: 3] = page_select;
                next_rdata[PCS_SEL_PORT_LSB +: 4] = port_select;
            end
            PCS_IDX_PSTAT: begin
                if (port_page_ok) begin
                    next_rdata[PCS_PS_ASTAT_LSB +: 2] = port_astat_in[port_select[1:0]];
                    next_rdata[PCS_PS_BSTAT_LSB +: 2] = port_bstat_in[port_select[1:0]];
                    next_rdata[PCS_PS_CHILD] = port_child_in[port_select[1:0]];
                    next_rdata[PCS_PS_CONN] = port_connected_in[port_select[1:0]];
                    next_rdata[PCS_PS_BIAS] = port_bias_in[port_select[1:0]];
                    next_rdata[PCS_PS_DIS] = pp_disabled[port_select[1:0]];
                end
            end
            PCS_IDX_PCTRL: begin
                if (port_page_ok) begin
                    next_rdata[PCS_PC_SPEED_LSB +: 3] = port_speed_in[port_select[1:0]];
                    next_rdata[PCS_PC_INT_EN] = pp_int_enable[port_select[1:0]];
                    next_rdata[PCS_PC_FAULT] = pp_fault[port_select[1:0]];
                end
            end
            default: begin
                next_rdata = 8'h0;
            end
        endcase
    end

    // ************************************************************
    // Power class with strap load
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            strap_s3 <= 3'h0;
        end else begin
            strap_s1 <= power_class_strap_pins_in;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    // Straps are caught once the synchroniser has filled after release
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            strap_count <= 2'h0;
            strap_loaded <= 1'b0;
        end else if (strap_count != PCS_STRAP_SETTLE) begin
            strap_count <= strap_count + 2'h1;
        end else if (strap_s2 == strap_s3) begin
            strap_loaded <= 1'b1;
        end
    end

    // Software write wins over the one-time strap load
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            pwr_class <= 3'h0;
        end else if (wr_pwr) begin
            pwr_class <= wbyte[PCS_PWR_LSB +: 3];
        end else if (!strap_loaded && strap_count == PCS_STRAP_SETTLE
                     && strap_s2 == strap_s3) begin
            pwr_class <= strap_s3;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            power_class_out <= 3'h0;
        end else begin
            power_class_out <= pwr_class;
        end
    end

    // ************************************************************
    // Cable power monitor
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            ps_s1 <= 1'b0;
            ps_s2 <= 1'b0;
            ps_s3 <= 1'b0;
        end else begin
            ps_s1 <= cable_power_present_in;
            ps_s2 <= ps_s1;
            ps_s3 <= ps_s2;
        end
    end

    // Starts low so power present at start-up raises no false loss
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            ps_state <= 1'b0;
        end else if (ps_s2 == ps_s3) begin
            ps_state <= ps_s3;
        end
    end

    assign ps_fall = ps_state & ~ps_s2 & ~ps_s3;

    // ************************************************************
    // Event and control register
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            resume_enable <= 1'b0;
            accel_enable <= 1'b0;
            multi_enable <= 1'b0;
        end else if (wr_evt) begin
            resume_enable <= wbyte[PCS_EV_RESUME_EN];
            accel_enable <= wbyte[PCS_EV_ACCEL];
            multi_enable <= wbyte[PCS_EV_MULTI];
        end
    end

    // Held until the arbiter reports the short reset is issued
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            short_reset_request_out <= 1'b0;
        end else if (wr_evt && wbyte[PCS_EV_SHORT_RST]) begin
            short_reset_request_out <= 1'b1;
        end else if (short_reset_done_in) begin
            short_reset_request_out <= 1'b0;
        end
    end

    // Flags: writing zero keeps them, a same-cycle event beats the clear
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            loop_flag <= 1'b0;
        end else begin
            loop_flag <= (loop_flag & ~(wr_evt & wbyte[PCS_EV_LOOP]))
                | loop_detect_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            pwr_fail_flag <= 1'b0;
        end else begin
            pwr_fail_flag <= (pwr_fail_flag & ~(wr_evt & wbyte[PCS_EV_PWR_FAIL]))
                | ps_fall;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            timeout_flag <= 1'b0;
        end else begin
            timeout_flag <= (timeout_flag & ~(wr_evt & wbyte[PCS_EV_TIMEOUT]))
                | arb_timeout_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            port_event_flag <= 1'b0;
        end else begin
            port_event_flag <= (port_event_flag & ~(wr_evt & wbyte[PCS_EV_PORT_EVT]))
                | (|pp_change)
                | (resume_enable & (|port_resume_start_in));
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            arb_accel_enable_out <= 1'b0;
            multi_speed_enable_out <= 1'b0;
        end else begin
            arb_accel_enable_out <= accel_enable;
            multi_speed_enable_out <= multi_enable;
        end
    end

    // ************************************************************
    // Page and port select
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            page_select <= PCS_PAGE_RESET;
            port_select <= PCS_PORT_RESET;
        end else if (wr_sel) begin
            page_select <= wbyte[PCS_SEL_PAGE_LSB +: 3];
            port_select <= wbyte[PCS_SEL_PORT_LSB +: 4];
        end
    end

    // ************************************************************
    // Per-port status
    // ************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < PCS_NUM_PORTS; gp++) begin : g_port
            assign pp_wr_status[gp] = wr_pstat & (port_select == 4'(gp));
            assign pp_wr_ctrl[gp] = wr_pctrl & (port_select == 4'(gp));
            pcs_port_status u_port (
                .clock_in(clock_in),
                .nrst_in(nrst_in),
                .connected_in(port_connected_in[gp]),
                .bias_in(port_bias_in[gp]),
                .fault_event_in(port_fault_event_in[gp]),
                .wr_status_in(pp_wr_status[gp]),
                .wr_ctrl_in(pp_wr_ctrl[gp]),
                .wdata_in(wbyte),
                .disabled_out(pp_disabled[gp]),
                .int_enable_out(pp_int_enable[gp]),
                .fault_out(pp_fault[gp]),
                .change_event_out(pp_change[gp])
            );
        end
    endgenerate

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            port_disabled_out <= '0;
        end else begin
            port_disabled_out <= pp_disabled;
        end
    end
endmodule

// ===== tb/pcs_arbiter_model.sv
`timescale 1ns/1ns
module pcs_arbiter_model #(
    parameter int DELAY = 20
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic request_in,
    output logic done_out
);
    int cnt;
    // Arbitrate, then report the short reset as finished
    always_ff @(posedge clock_in) begin
        if (!nrst_in || !request_in || done_out) begin
            cnt <= 0;
            done_out <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            done_out <= (cnt == DELAY);
        end
    end
endmodule

// ===== tb/pcs_regs_props.sv
`timescale 1ns/1ns
module pcs_regs_props
    import pcs_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic short_reset_done_in,
    input wire logic [2:0] power_class_out,
    input wire logic short_reset_request_out,
    input wire logic arb_accel_enable_out,
    input wire logic multi_speed_enable_out,
    input wire logic [PCS_NUM_PORTS-1:0] port_disabled_out
);
    logic wr_p, rd_p, wd, rdn;
    logic [3:0] a_idx;
    logic [7:0] sel;
    assign wd = wr_p && hready_in;
    assign rdn = rd_p && hready_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // Shadow of the bus phases and of the window select
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            wr_p <= 1'b0;
            rd_p <= 1'b0;
            a_idx <= 4'h0;
            sel <= 8'h00;
        end else begin
            if (hready_in) begin
                wr_p <= hsel_in && htrans_in[1] && hwrite_in;
                rd_p <= hsel_in && htrans_in[1] && !hwrite_in;
                a_idx <= haddr_in[5:2];
            end
            if (wd && a_idx == PCS_IDX_SEL) begin
                sel <= hwdata_in[7:0];
            end
        end
    end
    AST_JITTER_ZERO: assert property (
        rdn && a_idx == PCS_IDX_PWR |-> hrdata_out[31:3] == 29'h0)
        else $error("delay spread not zero");
    AST_PWR_COPY: assert property (
        wd && a_idx == PCS_IDX_PWR |-> ##2 power_class_out == $past(hwdata_in[2:0], 2))
        else $error("power class output wrong");
    AST_SRR_SET: assert property (
        wd && a_idx == PCS_IDX_EVT && hwdata_in[6] |-> ##[1:2] short_reset_request_out)
        else $error("short reset not requested");
    AST_SRR_CLEAR: assert property (
        short_reset_done_in |-> ##[1:2] !short_reset_request_out)
        else $error("short reset not cleared");
    AST_ENABLE_COPY: assert property (
        wd && a_idx == PCS_IDX_EVT |-> ##2
        {arb_accel_enable_out, multi_speed_enable_out} == $past(hwdata_in[1:0], 2))
        else $error("enable outputs wrong");
    AST_WINDOW_EMPTY: assert property (
        rdn && a_idx[3:1] == 3'h4 && (sel[7:5] != 3'h0 || sel[3:0] >= PCS_NUM_PORTS)
        |-> hrdata_out == 32'h0)
        else $error("window not empty");
    AST_DISABLE_COPY: assert property (
        wd && a_idx == PCS_IDX_PSTAT && sel[7:5] == 3'h0 && sel[3:0] < PCS_NUM_PORTS
        |-> ##2 port_disabled_out[$past(sel[1:0], 2)] == $past(hwdata_in[0], 2))
        else $error("port disable output wrong");
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        !nrst_in |=> !short_reset_request_out && !arb_accel_enable_out
        && !multi_speed_enable_out && port_disabled_out == '0 && power_class_out == 3'h0)
        else $error("outputs not cleared by reset");
endmodule
bind pcs_regs pcs_regs_props chk_i (.clock_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .short_reset_done_in, .power_class_out,
    .short_reset_request_out, .arb_accel_enable_out, .multi_speed_enable_out,
    .port_disabled_out);

// ===== tb/pcs_regs_bench.sv
`timescale 1ns/1ns
module pcs_regs_bench import pcs_pkg::*;;
    logic clock_in = 1'b0, nrst_in = 1'b0;
    logic hsel_in = 1'b0, hwrite_in = 1'b0;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2;
    logic [31:0] haddr_in = 32'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic [2:0] power_class_strap_pins_in = 3'h5;
    logic cable_power_present_in = 1'b1;
    logic loop_detect_in = 1'b0, arb_timeout_in = 1'b0;
    logic [PCS_NUM_PORTS-1:0][1:0] port_astat_in = 6'h04;
    logic [PCS_NUM_PORTS-1:0][1:0] port_bstat_in = 6'h08;
    logic [PCS_NUM_PORTS-1:0][2:0] port_speed_in = 9'h010;
    logic [PCS_NUM_PORTS-1:0] port_child_in = 3'h2;
    logic [PCS_NUM_PORTS-1:0] port_connected_in = 3'h2;
    logic [PCS_NUM_PORTS-1:0] port_bias_in = 3'h0;
    logic [PCS_NUM_PORTS-1:0] port_fault_event_in = 3'h0;
    logic [PCS_NUM_PORTS-1:0] port_resume_start_in = 3'h0;
    logic [31:0] hrdata_out;
    logic hreadyout_out;
    logic [1:0] hresp_out;
    logic [2:0] power_class_out;
    logic short_reset_request_out, short_reset_done_in;
    logic arb_accel_enable_out, multi_speed_enable_out;
    logic [PCS_NUM_PORTS-1:0] port_disabled_out;
    wire logic hready_in = hreadyout_out;
    int error_cnt = 0, checks = 0, cyc = 0;
    logic [31:0] rd;

    pcs_regs dut (.clock_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
        .power_class_strap_pins_in, .cable_power_present_in, .port_astat_in, .port_bstat_in,
        .port_child_in, .port_connected_in, .port_bias_in, .port_speed_in,
        .port_fault_event_in, .port_resume_start_in, .loop_detect_in, .arb_timeout_in,
        .short_reset_done_in, .power_class_out, .short_reset_request_out,
        .arb_accel_enable_out, .multi_speed_enable_out, .port_disabled_out);
    pcs_arbiter_model #(.DELAY(20)) arb (.clock_in, .nrst_in,
        .request_in(short_reset_request_out), .done_out(short_reset_done_in));

    always #5 clock_in = ~clock_in;
    // ****************
    // Bus tasks
    // ****************
    task chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clock_in);
        hsel_in <= 1'b1;
        htrans_in <= PCS_HTRANS_NONSEQ_BIT;
        haddr_in <= {26'h0, idx, 2'h0};
        hwrite_in <= w;
        do @(posedge clock_in); while (hready_in !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= {24'h0, d};
        do @(posedge clock_in); while (hready_in !== 1'b1);
        rd = hrdata_out;
        chk({30'h0, hresp_out}, 32'h0);
    endtask
    task wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task rdc(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run needs about 260 cycles
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        rdc(PCS_IDX_EVT, 8'h00);
        rdc(PCS_IDX_SEL, 8'h00);
        rdc(PCS_IDX_PWR, 8'h05);
        rdc(4'h6, 8'h00);
        $display("done: reset values");
        for (int i = 0; i < 8; i++) begin
            wr(PCS_IDX_PWR, 8'hF8 | 8'(i));
            rdc(PCS_IDX_PWR, 8'(i));
            chk({29'h0, power_class_out}, i);
        end
        $display("done: power class");
        wr(PCS_IDX_EVT, 8'h83);
        rdc(PCS_IDX_EVT, 8'h83);
        chk({30'h0, arb_accel_enable_out, multi_speed_enable_out}, 3);
        @(posedge clock_in);
        loop_detect_in <= 1'b1;
        arb_timeout_in <= 1'b1;
        @(posedge clock_in);
        arb_timeout_in <= 1'b0;
        rdc(PCS_IDX_EVT, 8'hAB);
        wr(PCS_IDX_EVT, 8'h83);
        rdc(PCS_IDX_EVT, 8'hAB);
        // Loop still high: set must beat the clear
        wr(PCS_IDX_EVT, 8'hAB);
        rdc(PCS_IDX_EVT, 8'hA3);
        loop_detect_in <= 1'b0;
        wr(PCS_IDX_EVT, 8'hA3);
        rdc(PCS_IDX_EVT, 8'h83);
        cable_power_present_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        rdc(PCS_IDX_EVT, 8'h93);
        wr(PCS_IDX_EVT, 8'h93);
        rdc(PCS_IDX_EVT, 8'h83);
        port_resume_start_in <= 3'h2;
        @(posedge clock_in);
        port_resume_start_in <= 3'h0;
        repeat (3) @(posedge clock_in);
        rdc(PCS_IDX_EVT, 8'h87);
        wr(PCS_IDX_EVT, 8'h07);
        port_resume_start_in <= 3'h4;
        @(posedge clock_in);
        port_resume_start_in <= 3'h0;
        repeat (3) @(posedge clock_in);
        rdc(PCS_IDX_EVT, 8'h03);
        $display("done: event flags");
        wr(PCS_IDX_EVT, 8'h43);
        rdc(PCS_IDX_EVT, 8'h43);
        for (int i = 0; i < 40 && short_reset_request_out; i++) @(posedge clock_in);
        rdc(PCS_IDX_EVT, 8'h03);
        $display("done: short reset");
        wr(PCS_IDX_SEL, 8'h01);
        rdc(PCS_IDX_PSTAT, 8'h6C);
        wr(PCS_IDX_PSTAT, 8'h01);
        rdc(PCS_IDX_PSTAT, 8'h6D);
        chk({29'h0, port_disabled_out}, 2);
        rdc(PCS_IDX_EVT, 8'h03);
        wr(PCS_IDX_PCTRL, 8'h10);
        rdc(PCS_IDX_PCTRL, 8'h50);
        port_bias_in <= 3'h2;
        repeat (4) @(posedge clock_in);
        rdc(PCS_IDX_EVT, 8'h07);
        wr(PCS_IDX_EVT, 8'h07);
        port_fault_event_in <= 3'h2;
        @(posedge clock_in);
        port_fault_event_in <= 3'h0;
        rdc(PCS_IDX_PCTRL, 8'h58);
        wr(PCS_IDX_PCTRL, 8'h18);
        rdc(PCS_IDX_PCTRL, 8'h50);
        wr(PCS_IDX_SEL, 8'h00);
        rdc(PCS_IDX_PSTAT, 8'h00);
        wr(PCS_IDX_SEL, 8'h21);
        rdc(PCS_IDX_PSTAT, 8'h00);
        wr(PCS_IDX_SEL, 8'h05);
        rdc(PCS_IDX_PCTRL, 8'h00);
        rdc(PCS_IDX_SEL, 8'h05);
        $display("done: port pages");
        report_and_stop;
    end
endmodule
